// *** hw/udc_pkg.sv ***
// shared constants and types of the up/down target counter
package udc_pkg;

  localparam int CNT_W = 17;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_TARGET  = 8'h04;
  localparam logic [7:0] ADDR_COUNT   = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;

  // control field positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_DIR_BIT  = 1;
  localparam int CTRL_HOLD_BIT = 2;
  localparam int CTRL_WCLR_BIT = 3;

  // status and interrupt field positions
  localparam int ST_TERM_BIT = 0;
  localparam int ST_WRAP_BIT = 1;

  // reset values and limits
  localparam logic [CNT_W-1:0] TARGET_RST = 17'h0270f;
  localparam logic [CNT_W-1:0] COUNT_MAX  = 17'h1869f;
  localparam logic [CNT_W-1:0] COUNT_RST  = 17'h00000;
  localparam logic             EN_RST     = 1'h0;
  localparam logic             DIR_RST    = 1'h0;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] tgt;
    logic             en;
    logic             dir;
    logic             hold;
    logic             wclr;
    logic             term;
    logic             wrap;
    logic [1:0]       ist;
    logic [1:0]       ien;
    logic [2:0]       sync;
    logic             rdy;
    logic             err;
    logic             irq;
    logic [31:0]      rdata;
  } udc_state_t;

endpackage

// *** hw/udc_counter.sv ***
// up/down target counter with apb registers and interrupt
//
// Functional notes
// - terminal flag output is 1 whenever count sits at its terminal value
// - wrap flag stays 1 after wrapping until explicitly cleared
// - count advances only on rising edges of the event input
// - programmable target, 9999 after reset
// - count spans 0 to 99999
// - while counter reset is 1, load 0 (up) or target (down)
// - counter reset also clears the wrap flag
// - wrap clear at 1 clears the wrap flag, count untouched
// - up mode increments per edge until target; terminal flag rises
// - up mode: edge at target wraps count to zero
// - up wrap edge sets wrap flag and drops terminal flag unless target is 0
// - down mode decrements per edge until zero
// - down mode: terminal flag rises when count reaches zero
// - down mode: edge at zero reloads the target
// - down reload edge sets wrap flag and drops terminal flag unless target is 0
// - count frozen while enable and counter reset are 0; enable defaults to 0
// - direction 0 counts up (default), 1 counts down
`timescale 1ns/1ps

module udc_counter
  import udc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        evtIn,
  output logic             terminalFlag,
  output logic             wrapFlag,
  output logic             irq
);

  udc_state_t s_r;
  udc_state_t s_nxt;

  logic evtEdge;
  logic apbAcc;
  logic apbFirst;
  logic apbDone;
  logic mapped;
  logic [31:0] rdVal;

  ////////////////////////////////////////////////////////////////////
  // event edge and bus decode

  // sync[0] feeds only sync[1]; the edge looks at the later stages
  assign evtEdge  = s_r.sync[1] & ~s_r.sync[2];
  assign apbAcc   = psel & penable;
  assign apbFirst = apbAcc & ~s_r.rdy;
  assign apbDone  = apbAcc & s_r.rdy;

  always_comb begin
    rdVal  = 32'h00000000;
    mapped = 1'b1;
    unique case (paddr)
      ADDR_CTRL: begin
        rdVal[CTRL_EN_BIT]   = s_r.en;
        rdVal[CTRL_DIR_BIT]  = s_r.dir;
        rdVal[CTRL_HOLD_BIT] = s_r.hold;
        rdVal[CTRL_WCLR_BIT] = s_r.wclr;
      end
      ADDR_TARGET: begin
        rdVal[CNT_W-1:0] = s_r.tgt;
      end
      ADDR_COUNT: begin
        rdVal[CNT_W-1:0] = s_r.cnt;
      end
      ADDR_STATUS: begin
        rdVal[ST_TERM_BIT] = s_r.term;
        rdVal[ST_WRAP_BIT] = s_r.wrap;
      end
      ADDR_IRQ_ST: begin
        rdVal[1:0] = s_r.ist;
      end
      ADDR_IRQ_EN: begin
        rdVal[1:0] = s_r.ien;
      end
      ADDR_IRQ_CLR: begin
        rdVal = 32'h00000000;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic wrapEv;
    logic [1:0] iev;
    logic [1:0] iclr;
    wrapEv = 1'b0;
    iev    = 2'h0;
    iclr   = 2'h0;
    s_nxt  = s_r;
    s_nxt.sync = {s_r.sync[1:0], evtIn};

    // counting; the hold level wins over any edge
    if (s_r.hold) begin
      s_nxt.cnt  = s_r.dir ? s_r.tgt : COUNT_RST;
      s_nxt.wrap = 1'b0;
    end else if (s_r.en && evtEdge) begin
      if (!s_r.dir) begin
        // >= guards a target lowered below the live count
        if (s_r.cnt >= s_r.tgt) begin
          s_nxt.cnt = COUNT_RST;
          wrapEv    = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt + 17'h00001;
        end
      end else begin
        if (s_r.cnt == COUNT_RST) begin
          s_nxt.cnt = s_r.tgt;
          wrapEv    = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt - 17'h00001;
        end
      end
    end

    // wrap flag: a wrap in the same cycle beats the clear
    if (s_r.wclr && !wrapEv) begin
      s_nxt.wrap = 1'b0;
    end
    if (wrapEv) begin
      s_nxt.wrap = 1'b1;
    end

    // apb: one wait state; data taken on the pready edge
    s_nxt.rdy = apbFirst;
    if (apbFirst) begin
      s_nxt.rdata = rdVal;
      s_nxt.err   = ~mapped;
    end else begin
      s_nxt.err   = 1'b0;
    end
    if (apbDone && pwrite) begin
      unique case (paddr)
        ADDR_CTRL: begin
          s_nxt.en   = pwdata[CTRL_EN_BIT];
          s_nxt.dir  = pwdata[CTRL_DIR_BIT];
          s_nxt.hold = pwdata[CTRL_HOLD_BIT];
          s_nxt.wclr = pwdata[CTRL_WCLR_BIT];
        end
        ADDR_TARGET: begin
          // out-of-range targets clamp to the count ceiling
          if (|pwdata[31:CNT_W] || pwdata[CNT_W-1:0] > COUNT_MAX) begin
            s_nxt.tgt = COUNT_MAX;
          end else begin
            s_nxt.tgt = pwdata[CNT_W-1:0];
          end
        end
        ADDR_IRQ_EN: begin
          s_nxt.ien = pwdata[1:0];
        end
        ADDR_IRQ_CLR: begin
          iclr = pwdata[1:0];
        end
        default: begin
          iclr = 2'h0;
        end
      endcase
    end

    // terminal flag follows the count it will sit beside
    s_nxt.term = s_nxt.dir ? (s_nxt.cnt == COUNT_RST)
                           : (s_nxt.cnt == s_nxt.tgt);

    // sticky interrupt status; set beats clear
    iev[ST_TERM_BIT] = s_nxt.term & ~s_r.term;
    iev[ST_WRAP_BIT] = wrapEv;
    s_nxt.ist = (s_r.ist & ~iclr) | iev;
    s_nxt.irq = |(s_nxt.ist & s_nxt.ien);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r       <= '0;
      s_r.tgt   <= TARGET_RST;
      s_r.en    <= EN_RST;
      s_r.dir   <= DIR_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata       = s_r.rdata;
  assign pready       = s_r.rdy;
  assign pslverr      = s_r.err;
  assign terminalFlag = s_r.term;
  assign wrapFlag     = s_r.wrap;
  assign irq          = s_r.irq;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_liveEdge;
    s_r.en && evtEdge && !s_r.hold;
  endsequence

  sequence s_upAtTarget;
    s_liveEdge ##0 (!s_r.dir && s_r.cnt == s_r.tgt);
  endsequence

  sequence s_downAtZero;
    s_liveEdge ##0 (s_r.dir && s_r.cnt == COUNT_RST);
  endsequence

  sequence s_upLastStep;
    s_liveEdge ##0 (!s_r.dir && s_r.cnt + 17'h00001 == s_r.tgt);
  endsequence

  sequence s_downLastStep;
    s_liveEdge ##0 (s_r.dir && s_r.cnt == 17'h00001);
  endsequence

  property p_termLevel;
    !s_r.dir && s_r.cnt == s_r.tgt |-> terminalFlag;
  endproperty
  a_termLevel: assert property (p_termLevel)
    else $error("terminal flag low at target");

  property p_upWrap;
    s_upAtTarget |=> (s_r.cnt == COUNT_RST) && wrapFlag
                     && (s_r.tgt == COUNT_RST || !terminalFlag);
  endproperty
  a_upWrap: assert property (p_upWrap)
    else $error("up wrap did not zero count or set wrap");

  property p_downReload;
    s_downAtZero |=> s_r.cnt == $past(s_r.tgt) && wrapFlag;
  endproperty
  a_downReload: assert property (p_downReload)
    else $error("down reload failed");

  property p_upInc;
    s_liveEdge ##0 (!s_r.dir && s_r.cnt < s_r.tgt)
      |=> s_r.cnt == $past(s_r.cnt) + 17'h00001;
  endproperty
  a_upInc: assert property (p_upInc)
    else $error("up count did not advance by one");

  property p_downDec;
    s_liveEdge ##0 (s_r.dir && s_r.cnt != COUNT_RST)
      |=> s_r.cnt == $past(s_r.cnt) - 17'h00001;
  endproperty
  a_downDec: assert property (p_downDec)
    else $error("down count did not drop by one");

  property p_frozen;
    !s_r.en && !s_r.hold |=> $stable(s_r.cnt);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("count moved while disabled");

  property p_holdLoad;
    s_r.hold |=> s_r.cnt == ($past(s_r.dir) ? $past(s_r.tgt) : COUNT_RST)
                 && !wrapFlag;
  endproperty
  a_holdLoad: assert property (p_holdLoad)
    else $error("counter reset load or wrap clear wrong");

  property p_levelIgnored;
    s_r.sync[2] && s_r.sync[1] && !s_r.hold |=> $stable(s_r.cnt);
  endproperty
  a_levelIgnored: assert property (p_levelIgnored)
    else $error("count moved on a steady level");

  property p_wrapSticky;
    wrapFlag && !s_r.wclr && !s_r.hold |=> wrapFlag;
  endproperty
  a_wrapSticky: assert property (p_wrapSticky)
    else $error("wrap flag dropped without a clear");

  property p_apbAnswer;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_apbAnswer: assert property (p_apbAnswer)
    else $error("apb answer not one wait state");

  property p_rangeCap;
    s_r.cnt <= COUNT_MAX;
  endproperty
  a_rangeCap: assert property (p_rangeCap)
    else $error("count above ceiling");

  property p_termDown;
    s_r.dir && s_r.cnt == COUNT_RST |-> terminalFlag;
  endproperty
  a_termDown: assert property (p_termDown)
    else $error("terminal flag low at zero");

  // the flag must also drop as soon as the terminal value is left
  property p_termOff;
    terminalFlag |-> (s_r.dir ? s_r.cnt == COUNT_RST : s_r.cnt == s_r.tgt);
  endproperty
  a_termOff: assert property (p_termOff)
    else $error("terminal flag high off the terminal value");

  property p_upTermRise;
    s_upLastStep |=> terminalFlag;
  endproperty
  a_upTermRise: assert property (p_upTermRise)
    else $error("terminal flag not raised at target");

  property p_downTermRise;
    s_downLastStep |=> terminalFlag && s_r.cnt == COUNT_RST;
  endproperty
  a_downTermRise: assert property (p_downTermRise)
    else $error("terminal flag not raised at zero");

  property p_downTermDrop;
    s_downAtZero ##0 (s_r.tgt != COUNT_RST) |=> !terminalFlag;
  endproperty
  a_downTermDrop: assert property (p_downTermDrop)
    else $error("terminal flag kept after reload");

  property p_wrapClear;
    s_r.wclr && !s_r.hold && !evtEdge |=> !wrapFlag && $stable(s_r.cnt);
  endproperty
  a_wrapClear: assert property (p_wrapClear)
    else $error("wrap clear failed or moved count");

  // only a sampled rising edge or the counter reset may move the count
  property p_edgeOnly;
    !evtEdge && !s_r.hold |=> $stable(s_r.cnt);
  endproperty
  a_edgeOnly: assert property (p_edgeOnly)
    else $error("count moved without an edge");

  property p_irqLevel;
    irq == |(s_r.ist & s_r.ien);
  endproperty
  a_irqLevel: assert property (p_irqLevel)
    else $error("interrupt level wrong");

endmodule

// *** test/udc_evt_src.sv ***
// event source model driving the counter's event pin
`timescale 1ns/1ps

module udc_evt_src (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic fire,
  output logic      evtIn,
  output logic      busy
);
  logic [2:0] step;

  ////////////////////////////////////////////////////////////////////////////
  // high two cycles, low three: spacing the two-flop sync needs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      step <= 3'h0;
    else if (fire && step == 3'h0)
      step <= 3'h5;
    else if (step != 3'h0)
      step <= step - 3'h1;
  end

  assign evtIn = (step >= 3'h4);
  assign busy  = fire || (step != 3'h0);
endmodule

// *** test/udc_counter_test.sv ***
// self-checking bench of the up/down target counter
`timescale 1ns/1ps

module udc_counter_test
  import udc_pkg::*;
;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        evtIn, terminalFlag, wrapFlag, irq, fire, busy;
  int          failures = 0;
  int          num_checks = 0;

  udc_counter udc_counter_i (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .evtIn(evtIn),
    .terminalFlag(terminalFlag), .wrapFlag(wrapFlag), .irq(irq));
  udc_evt_src udc_evt_src_i (.sys_clk(sys_clk), .rst(rst), .fire(fire),
    .evtIn(evtIn), .busy(busy));

  always #12.5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // no wait-state count assumed; only the watchdog ends a hung wait
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // extra edges let registered flags settle
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic chk(input string s, input logic [31:0] x,
                     input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      failures++;
      $display("[ERR] %s exp %h got %h", s, x, g);
    end
  endtask

  task automatic chkr(input string s, input logic [7:0] a,
                      input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(s, x, q);
    chk({s, " err"}, {31'h0, (a > ADDR_IRQ_CLR)}, {31'h0, e});
  endtask

  task automatic pulse();
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    while (busy !== 1'b0) begin
      @(posedge sys_clk);
    end
    repeat (2) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    finish_test();
  end

  initial begin
    sys_clk = 1'h0;
    rst     = 1'h1;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 8'h00;
    pwdata  = 32'h00000000;
    fire    = 1'h0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chkr("target", ADDR_TARGET, 32'h0000270f);
    chkr("ctrl", ADDR_CTRL, 32'h0);
    chkr("unmapped", 8'h1c, 32'h0);
    pulse();
    chkr("count", ADDR_COUNT, 32'h0);
    wr(ADDR_TARGET, 32'h1ffff);
    chkr("clamp", ADDR_TARGET, 32'h0001869f);
    wr(ADDR_TARGET, 32'h2);
    wr(ADDR_IRQ_EN, 32'h3);
    wr(ADDR_CTRL, 32'h1);
    pulse();
    pulse();
    chkr("count", ADDR_COUNT, 32'h2);
    chk("term", 32'h1, {31'h0, terminalFlag});
    pulse();
    chkr("count", ADDR_COUNT, 32'h0);
    chkr("status", ADDR_STATUS, 32'h2);
    chkr("irqst", ADDR_IRQ_ST, 32'h3);
    chk("irq", 32'h1, {31'h0, irq});
    wr(ADDR_IRQ_EN, 32'h0);
    chk("irq mask", 32'h0, {31'h0, irq});
    wr(ADDR_IRQ_CLR, 32'h3);
    chkr("irqst clr", ADDR_IRQ_ST, 32'h0);
    pulse();
    chk("wrap", 32'h1, {31'h0, wrapFlag});
    wr(ADDR_CTRL, 32'h9);
    wr(ADDR_CTRL, 32'h1);
    chk("wrap clr", 32'h0, {31'h0, wrapFlag});
    chkr("count", ADDR_COUNT, 32'h1);
    wr(ADDR_CTRL, 32'h7);
    chkr("load", ADDR_COUNT, 32'h2);
    wr(ADDR_CTRL, 32'h3);
    pulse();
    pulse();
    chkr("count dn", ADDR_COUNT, 32'h0);
    chk("term dn", 32'h1, {31'h0, terminalFlag});
    pulse();
    chkr("reload", ADDR_COUNT, 32'h2);
    chkr("status dn", ADDR_STATUS, 32'h2);
    wr(ADDR_CTRL, 32'h7);
    chk("wrap rst", 32'h0, {31'h0, wrapFlag});
    pulse();
    chkr("held", ADDR_COUNT, 32'h2);
    wr(ADDR_CTRL, 32'h5);
    chkr("load up", ADDR_COUNT, 32'h0);
    wr(ADDR_CTRL, 32'h1);
    pulse();
    chkr("count up", ADDR_COUNT, 32'h1);
    wr(ADDR_COUNT, 32'h5);
    chkr("ro count", ADDR_COUNT, 32'h1);
    chkr("clr reads", ADDR_IRQ_CLR, 32'h0);
    finish_test();
  end
endmodule
